// *** src/stc_regs.svh ***
`ifndef STC_REGS_SVH
`define STC_REGS_SVH
// What this block does
// - safety outputs stay open for the whole teach-in
// - door, start or feedback change in teach-in: fault, red lamp, three flashes
// - taught channels, actuator codes, start mode and feedback kept as configuration
// - teach-in may be repeated without limit, each replacing the stored set
// - actuator code not taught in latest teach-in counts as absent
// - jumper fitted with power off; found at power-up it selects teach-in
// - switches 1 to 4 mark which read-head channels are used
// - switch 5 off gives automatic start, on gives manual start
// - switch 6 on means a feedback loop is connected and monitored
// - after power-up a ten second self-test flashes status at 15 Hz
// - status lamp flashes at about 1 Hz during teach-in
// - status lamp goes dark as acknowledge about ten seconds after teach-in starts
// - after acknowledge, monitoring outputs show actuators within distance of each head
// - guard open: status lamp steady, output and red lamp dark, outputs off
// - all guards and safety circuit closed: status and output lamps steady
// - red lamp for operating, feedback, teach-in or internal fault, or function test
// - welded relay contact found no later than next guard opening
// - function-test input acts as open guard and switches outputs off
// - function-test release: diagnostic output high, red lamp off, normal operation
// - manual start: after function test outputs stay off until start pressed

// apb map
`define STC_OFS_CTRL        12'h000
`define STC_OFS_STATUS      12'h004
`define STC_OFS_CFG         12'h008
`define STC_OFS_CODES       12'h00c
`define STC_CTRL_RESTART    0
// status fields
`define STC_ST_STATE_LSB    0
`define STC_ST_SAFE_LSB     3
`define STC_ST_LED_STATE    5
`define STC_ST_LED_OUT      6
`define STC_ST_LED_DIA      7
`define STC_ST_DIAG         8
`define STC_ST_MON_LSB      9
`define STC_ST_F_TEACH      13
`define STC_ST_F_FB         14
`define STC_ST_F_INT        15
`define STC_ST_FTEST        16
`define STC_ST_CLOSED       17
// cfg fields
`define STC_CFG_CHAN_LSB    0
`define STC_CFG_MANUAL      4
`define STC_CFG_FB          5
`define STC_CFG_VALID       6
// dip switch positions (switch n at bit n-1)
`define STC_DIP_CHAN_LSB    0
`define STC_DIP_MANUAL      4
`define STC_DIP_FB          5
// reset values
`define STC_RST_WORD        32'h0000_0000
`define STC_RST_PINS        12'h000
// timing
`define STC_CLK_HZ          250000000
`define STC_TICK_US         1000
`define STC_TICK_CYCLES     (`STC_CLK_HZ / 1000000 * `STC_TICK_US)
`define STC_SELFTEST_MS     10000
`define STC_TEACH_MS        10000
`define STC_SELFTEST_TICKS  (`STC_SELFTEST_MS * 1000 / `STC_TICK_US)
`define STC_TEACH_TICKS     (`STC_TEACH_MS * 1000 / `STC_TICK_US)
`define STC_FAST_HZ         15
`define STC_FAST_HALF       (1000000 / (2 * `STC_FAST_HZ * `STC_TICK_US))
`define STC_PERIOD_TICKS    (1000000 / `STC_TICK_US)
`define STC_HALF_1HZ        (`STC_PERIOD_TICKS / 2)
`define STC_QUARTER_4HZ     (`STC_PERIOD_TICKS / 8)
`define STC_SHORT_FLASH     (`STC_PERIOD_TICKS / 10)
`define STC_SETTLE_MS       20
`define STC_SETTLE_TICKS    (`STC_SETTLE_MS * 1000 / `STC_TICK_US)
`endif

// *** src/stc_pkg.sv ***
package stc_pkg;
  typedef enum logic [2:0] {
    STC_SELFTEST    = 3'b000,
    STC_TEACH       = 3'b001,
    STC_TEACH_ACK   = 3'b011,
    STC_RUN         = 3'b010,
    STC_UNCONF      = 3'b110,
    STC_TEACH_FAULT = 3'b111,
    STC_FAULT       = 3'b101
  } stc_state_t;

  typedef struct packed {
    logic [5:0] dip;
    logic       teach_jumper_b;
    logic       start_btn;
    logic       feedback;
    logic       function_test_input;
    logic [1:0] relay_open;
  } stc_pins_t;

  typedef struct packed {
    logic [3:0]  chan;
    logic        manual;
    logic        fb;
    logic        valid;
    logic [31:0] code;
  } stc_cfg_t;

  typedef struct packed {
    stc_state_t  st;
    logic [13:0] timer;
    logic [9:0]  phase;
    logic [5:0]  fcnt;
    logic        fbit;
    logic [5:0]  snap;
    logic        start_q;
    logic        armed;
    logic [4:0]  off_ms;
    logic [1:0]  safety;
    logic        led_state;
    logic        led_out;
    logic        led_dia;
    logic        diag;
    logic [3:0]  monitor;
    logic        f_teach;
    logic        f_fb;
    logic        f_int;
    stc_cfg_t    cfg;
    logic [31:0] prdata;
    logic        slverr;
  } stc_core_t;
endpackage

// *** src/stc_sync3.sv ***
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_sync3 #(
  parameter int          WIDTH   = 12,
  parameter logic [11:0] RST_VAL = `STC_RST_PINS
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  initial begin
    if (WIDTH < 1 || WIDTH > 12) $error("stc_sync3: WIDTH out of range");
  end

  // a bit moves only when stages two and three agree, so a single glitch never counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= RST_VAL[WIDTH-1:0];
      s2_r <= RST_VAL[WIDTH-1:0];
      s3_r <= RST_VAL[WIDTH-1:0];
      dout <= RST_VAL[WIDTH-1:0];
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (s2_r & s3_r) | (dout & (s2_r ^ s3_r));
    end
  end
endmodule // stc_sync3

// *** src/stc_tick.sv ***
`timescale 1ns/1ps
module stc_tick #(
  parameter int TICK_CYCLES = 250000
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);
  logic [31:0] cnt_r;

  initial begin
    if (TICK_CYCLES < 2) $error("stc_tick: TICK_CYCLES below 2");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (cnt_r == 32'(TICK_CYCLES - 1)) begin
      cnt_r <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule // stc_tick

// *** src/stc_top.sv ***
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "stc_regs.svh"
module stc_top #(
  parameter int TICK_CYCLES    = `STC_TICK_CYCLES,
  parameter int SELFTEST_TICKS = `STC_SELFTEST_TICKS,
  parameter int TEACH_TICKS    = `STC_TEACH_TICKS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire stc_pkg::stc_pins_t pins,
  input  wire logic [3:0]        head_present,
  input  wire logic [31:0]       head_code,
  output logic                   teach_jumper_a,
  output logic      [1:0]        safety_out,
  output logic                   led_state,
  output logic                   led_out,
  output logic                   led_dia,
  output logic                   diagnostic_output,
  output logic      [3:0]        monitor_out
);
  stc_pkg::stc_core_t r;
  stc_pkg::stc_core_t n;
  stc_pkg::stc_pins_t ps;
  logic               ms_tick;
  logic [3:0]         chan_ok;
  logic               closed;
  logic               permit;
  logic               restart;
  logic               wr_en;
  logic [5:0]         live;
  logic               three_flash;
  logic [9:0]         ph_mod;

  initial begin
    if (SELFTEST_TICKS < 1 || SELFTEST_TICKS > 16383) $error("stc_top: SELFTEST_TICKS");
    if (TEACH_TICKS < 1 || TEACH_TICKS > 16383) $error("stc_top: TEACH_TICKS");
  end

  stc_sync3 #(
    .WIDTH   (12),
    .RST_VAL (`STC_RST_PINS)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pins),
    .dout    (ps)
  );

  stc_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ms_tick)
  );

  // jumper sense is driven from here and read back on the other terminal
  assign teach_jumper_a    = 1'b1;
  assign pready            = 1'b1;
  assign prdata            = r.prdata;
  assign pslverr           = r.slverr;
  assign safety_out        = r.safety;
  assign led_state         = r.led_state;
  assign led_out           = r.led_out;
  assign led_dia           = r.led_dia;
  assign diagnostic_output = r.diag;
  assign monitor_out       = r.monitor;

  assign wr_en   = psel & penable & pwrite;
  assign restart = wr_en && paddr == `STC_OFS_CTRL && pwdata[`STC_CTRL_RESTART];

  // a channel only counts closed with the code taught last; any other actuator is absent
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chan_ok[i] = !r.cfg.chan[i] ||
                   (head_present[i] && head_code[i*8 +: 8] == r.cfg.code[i*8 +: 8]);
    end
  end
  assign closed = (&chan_ok) && r.cfg.chan != 4'h0;

  assign live        = {ps.start_btn, ps.feedback, head_present & ps.dip[3:0]};
  assign ph_mod      = r.phase % 10'(2 * `STC_QUARTER_4HZ);
  assign three_flash = r.phase < 10'(6 * `STC_SHORT_FLASH) &&
                       ((r.phase / 10'(`STC_SHORT_FLASH)) % 10'h002) == 10'h000;

  // relays may only close from a known open state, with feedback closed if monitored
  assign permit = closed && !ps.function_test_input &&
                  (!r.cfg.manual || r.armed) &&
                  (r.safety != 2'b00 || ps.relay_open == 2'b11) &&
                  (!r.cfg.fb || r.safety != 2'b00 || ps.feedback);

  always_comb begin
    n = r;
    n.start_q = ps.start_btn;
    // free running one second phase and 15 Hz toggle
    if (ms_tick) begin
      n.phase = (r.phase == 10'(`STC_PERIOD_TICKS - 1)) ? 10'h000 : r.phase + 10'h001;
      if (r.fcnt == 6'(`STC_FAST_HALF - 1)) begin
        n.fcnt = 6'h00;
        n.fbit = !r.fbit;
      end else begin
        n.fcnt = r.fcnt + 6'h01;
      end
    end
    // apb: read data captured in setup, no wait states
    if (psel && !penable) begin
      n.slverr = 1'b0;
      if (paddr == `STC_OFS_CTRL) begin
        n.prdata = `STC_RST_WORD;
      end else if (paddr == `STC_OFS_STATUS) begin
        n.prdata = {14'h0000, closed, ps.function_test_input, r.f_int, r.f_fb, r.f_teach,
                    r.monitor, r.diag, r.led_dia, r.led_out, r.led_state, r.safety, r.st};
      end else if (paddr == `STC_OFS_CFG) begin
        n.prdata = {25'h0000000, r.cfg.valid, r.cfg.fb, r.cfg.manual, r.cfg.chan};
      end else if (paddr == `STC_OFS_CODES) begin
        n.prdata = r.cfg.code;
      end else begin
        n.prdata = `STC_RST_WORD;
        n.slverr = 1'b1;
      end
    end
    case (r.st)
      stc_pkg::STC_SELFTEST: begin
        n.safety    = 2'b00;
        n.led_state = r.fbit;
        n.led_out   = 1'b0;
        n.led_dia   = 1'b0;
        n.diag      = 1'b1;
        n.monitor   = 4'h0;
        if (ms_tick) begin
          n.timer = r.timer + 14'h0001;
          if (r.timer == 14'(SELFTEST_TICKS - 1)) begin
            n.timer = 14'h0000;
            n.phase = 10'h000;
            if (ps.teach_jumper_b) begin
              n.st   = stc_pkg::STC_TEACH;
              n.snap = live;
            end else if (r.cfg.valid) begin
              n.st    = stc_pkg::STC_RUN;
              n.armed = 1'b0;
            end else begin
              n.st = stc_pkg::STC_UNCONF;
            end
          end
        end
      end
      stc_pkg::STC_TEACH: begin
        n.safety    = 2'b00;
        n.led_state = r.phase < 10'(`STC_HALF_1HZ);
        n.led_out   = 1'b0;
        if (live != r.snap) begin
          n.st      = stc_pkg::STC_TEACH_FAULT;
          n.f_teach = 1'b1;
          n.led_dia = 1'b1;
        end else if (ms_tick) begin
          n.timer = r.timer + 14'h0001;
          if (r.timer == 14'(TEACH_TICKS - 1)) begin
            if (ps.dip[3:0] == 4'h0) begin
              n.st      = stc_pkg::STC_TEACH_FAULT;
              n.f_teach = 1'b1;
              n.led_dia = 1'b1;
            end else begin
              // each teach-in overwrites the whole set, no count kept
              n.cfg.chan   = ps.dip[`STC_DIP_CHAN_LSB +: 4];
              n.cfg.manual = ps.dip[`STC_DIP_MANUAL];
              n.cfg.fb     = ps.dip[`STC_DIP_FB];
              n.cfg.code   = head_code;
              n.cfg.valid  = 1'b1;
              n.st         = stc_pkg::STC_TEACH_ACK;
              n.led_state  = 1'b0;
            end
          end
        end
      end
      stc_pkg::STC_TEACH_ACK: begin
        n.safety    = 2'b00;
        n.led_state = 1'b0;
        n.monitor   = head_present;
      end
      stc_pkg::STC_TEACH_FAULT: begin
        n.safety    = 2'b00;
        n.led_dia   = 1'b1;
        n.led_state = three_flash;
      end
      stc_pkg::STC_UNCONF: begin
        n.safety    = 2'b00;
        n.led_state = ph_mod < 10'(`STC_QUARTER_4HZ);
      end
      stc_pkg::STC_FAULT: begin
        n.safety    = 2'b00;
        n.led_out   = 1'b0;
        n.led_dia   = 1'b1;
        n.led_state = 1'b1;
      end
      stc_pkg::STC_RUN: begin
        n.monitor = 4'h0;
        if (!closed || ps.function_test_input) begin
          n.armed = 1'b0;
        end else if (ps.start_btn && !r.start_q) begin
          n.armed = 1'b1;
        end
        if (r.safety != 2'b00) begin
          n.off_ms = 5'h00;
        end else if (ms_tick && r.off_ms != 5'(`STC_SETTLE_TICKS)) begin
          n.off_ms = r.off_ms + 5'h01;
        end
        n.safety    = permit ? 2'b11 : 2'b00;
        n.led_state = 1'b1;
        n.led_out   = permit;
        n.led_dia   = ps.function_test_input;
        n.diag      = !ps.function_test_input;
        // each opening lets the relays drop, and the settled contacts are checked then
        if (r.safety == 2'b00 && r.off_ms == 5'(`STC_SETTLE_TICKS)) begin
          if (ps.relay_open != 2'b11) begin
            n.st     = stc_pkg::STC_FAULT;
            n.f_int  = 1'b1;
            n.safety = 2'b00;
          end else if (r.cfg.fb && !ps.feedback) begin
            n.st     = stc_pkg::STC_FAULT;
            n.f_fb   = 1'b1;
            n.safety = 2'b00;
          end
        end
      end
      default: begin
        n.st     = stc_pkg::STC_FAULT;
        n.f_int  = 1'b1;
        n.safety = 2'b00;
      end
    endcase
    // restart stands for a power cycle: stored configuration survives it
    if (restart) begin
      n.st        = stc_pkg::STC_SELFTEST;
      n.timer     = 14'h0000;
      n.safety    = 2'b00;
      n.led_out   = 1'b0;
      n.led_dia   = 1'b0;
      n.diag      = 1'b1;
      n.monitor   = 4'h0;
      n.f_teach   = 1'b0;
      n.f_fb      = 1'b0;
      n.f_int     = 1'b0;
      n.armed     = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r      <= '0;
      r.st   <= stc_pkg::STC_SELFTEST;
      r.diag <= 1'b1;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_teach_open;
    (r.st == stc_pkg::STC_TEACH || r.st == stc_pkg::STC_TEACH_ACK) |-> safety_out == 2'b00;
  endproperty
  a_teach_open: assert property (p_teach_open) else $error("outputs closed in teach-in");

  sequence s_teach_disturbed;
    r.st == stc_pkg::STC_TEACH && !restart && live != r.snap;
  endsequence
  property p_teach_abort;
    s_teach_disturbed |=> r.st == stc_pkg::STC_TEACH_FAULT && led_dia ##1 led_dia;
  endproperty
  a_teach_abort: assert property (p_teach_abort) else $error("teach change not caught");

  property p_fast_flash;
    r.st == stc_pkg::STC_SELFTEST && !restart && ms_tick && r.fcnt == 6'(`STC_FAST_HALF - 1)
      && r.timer != 14'(SELFTEST_TICKS - 1) && led_state == r.fbit
      |=> ##1 led_state != $past(led_state, 2);
  endproperty
  a_fast_flash: assert property (p_fast_flash) else $error("self-test flash wrong");

  sequence s_teach_done;
    r.st == stc_pkg::STC_TEACH && !restart && live == r.snap && ms_tick &&
    r.timer == 14'(TEACH_TICKS - 1) && ps.dip[3:0] != 4'h0;
  endsequence
  property p_teach_ack;
    s_teach_done |=> r.st == stc_pkg::STC_TEACH_ACK && !led_state && r.cfg.valid
                     && r.cfg.chan == $past(ps.dip[3:0]);
  endproperty
  a_teach_ack: assert property (p_teach_ack) else $error("teach-in not stored");

  property p_guard_open;
    r.st == stc_pkg::STC_RUN && !restart && !closed |=> safety_out == 2'b00 && !led_out
                                                        && led_state;
  endproperty
  a_guard_open: assert property (p_guard_open) else $error("open guard not safe");

  property p_out_lamp;
    safety_out != 2'b00 |-> led_out && led_state && !led_dia;
  endproperty
  a_out_lamp: assert property (p_out_lamp) else $error("lamps disagree with outputs");

  property p_ftest;
    r.st == stc_pkg::STC_RUN && !restart && ps.function_test_input
      |=> safety_out == 2'b00 && !diagnostic_output && led_dia;
  endproperty
  a_ftest: assert property (p_ftest) else $error("function test not honoured");

  property p_ftest_manual;
    r.st == stc_pkg::STC_RUN && r.cfg.manual && $fell(ps.function_test_input) && !ps.start_btn
      |-> (safety_out == 2'b00)[*2];
  endproperty
  a_ftest_manual: assert property (p_ftest_manual) else $error("restart without button");

  property p_weld;
    r.st == stc_pkg::STC_RUN && !restart && r.safety == 2'b00 &&
    r.off_ms == 5'(`STC_SETTLE_TICKS) && ps.relay_open != 2'b11
      |=> r.st == stc_pkg::STC_FAULT ##1 led_dia;
  endproperty
  a_weld: assert property (p_weld) else $error("welded contact missed");

  // self-test never closes a relay, whatever the stored set says
  property p_selftest_dark;
    r.st == stc_pkg::STC_SELFTEST && !restart
      |=> safety_out == 2'b00 && !led_out && !led_dia;
  endproperty
  a_selftest_dark: assert property (p_selftest_dark) else $error("lamps lit in self-test");

  property p_ack_dark;
    r.st == stc_pkg::STC_TEACH_ACK && !restart |=> !led_state && !led_out && safety_out == 2'b00;
  endproperty
  a_ack_dark: assert property (p_ack_dark) else $error("acknowledge not dark");

  property p_monitor_ack;
    r.st == stc_pkg::STC_TEACH_ACK && !restart |=> monitor_out == $past(head_present);
  endproperty
  a_monitor_ack: assert property (p_monitor_ack) else $error("monitor not following heads");

  // monitoring outputs are a setup aid only, never live in run
  property p_monitor_idle;
    monitor_out != 4'h0 |-> r.st == stc_pkg::STC_TEACH_ACK;
  endproperty
  a_monitor_idle: assert property (p_monitor_idle) else $error("monitor lit outside setup");

  property p_ftest_release;
    r.st == stc_pkg::STC_RUN && !restart && !ps.function_test_input
      |=> diagnostic_output && !led_dia;
  endproperty
  a_ftest_release: assert property (p_ftest_release) else $error("test release not seen");
endmodule // stc_top

// *** dv/stc_field.sv ***
`timescale 1ns/1ps
module stc_field (
  input  wire logic               pclk,
  input  wire logic [5:0]         dip,
  input  wire logic               jumper,
  input  wire logic               start,
  input  wire logic               fb_closed,
  input  wire logic               ftest,
  input  wire logic               weld,
  input  wire logic [3:0]         guard,
  input  wire logic [31:0]        code,
  input  wire logic [1:0]         safety_out,
  output stc_pkg::stc_pins_t      pins,
  output logic      [3:0]         head_present,
  output logic      [31:0]        head_code
);
  logic [1:0] relay_open_r = 2'b11;
  // contacts lag the drive; a welded pair never reopens
  always_ff @(posedge pclk) begin
    relay_open_r <= weld ? 2'b00 : ~safety_out;
  end
  // switches, jumper, button and loop are the operator's levels
  assign pins = {dip, jumper, start, fb_closed, ftest, relay_open_r};
  assign head_present = guard;
  // an absent actuator gives no valid code, so show a wrong one
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      head_code[8*i +: 8] = guard[i] ? code[8*i +: 8] : ~code[8*i +: 8];
    end
  end
endmodule // stc_field

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, head_code, code = 32'h0;
  logic        pready, pslverr, led_state, led_out, led_dia, diagnostic_output, jumper_a;
  logic [5:0]  dip = 6'h00;
  logic        jumper = 1'b0, start = 1'b1, fb_closed = 1'b1, ftest = 1'b0, weld = 1'b0;
  logic [3:0]  guard = 4'hf, head_present, monitor_out;
  logic [1:0]  safety_out;
  logic [65:0] ent;
  logic [65:0] exp_q[$];
  stc_pkg::stc_pins_t pins;
  integer      seed = 32'hb66054d3;
  int          error_cnt = 0, samples_checked = 0;

  always #2 pclk = ~pclk;

  stc_top #(.TICK_CYCLES(4), .SELFTEST_TICKS(20), .TEACH_TICKS(20)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .head_present(head_present), .head_code(head_code), .teach_jumper_a(jumper_a),
    .safety_out(safety_out), .led_state(led_state), .led_out(led_out), .led_dia(led_dia),
    .diagnostic_output(diagnostic_output), .monitor_out(monitor_out));

  stc_field field (
    .pclk(pclk), .dip(dip), .jumper(jumper & jumper_a), .start(start), .fb_closed(fb_closed),
    .ftest(ftest), .weld(weld), .guard(guard), .code(code), .safety_out(safety_out),
    .pins(pins), .head_present(head_present), .head_code(head_code));

  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] e, input logic [32:0] m);
    samples_checked++;
    if ((got & m) !== (e & m)) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got & m, e & m);
    end
  endtask

  // pins: monitor[9:6] safety[5:4] state lamp, out lamp, red lamp, diagnostic
  task automatic chk_pin(input logic [9:0] e, input logic [9:0] m);
    cmp({23'h0, monitor_out, safety_out, led_state, led_out, led_dia, diagnostic_output},
        {23'h0, e}, {23'h0, m});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // hold the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // bit 32 of value and mask is the error response
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic restart(input int n);
    apb(1'b1, 12'h000, 32'h1);
    cyc(n);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      ent = exp_q.pop_front();
      cmp({pslverr, prdata}, ent[32:0], ent[65:33]);
    end
  end

  initial begin
    #50000;
    error_cnt++;
    stop_test();
  end

  initial begin
    code <= $random(seed);
    cyc(3);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_pin(10'h001, 10'h3ff);
    rd(12'h004, 33'h0, 33'h7);
    rd(12'h010, 33'h1_0000_0000, 33'h1_ffff_ffff);
    cyc(100);
    rd(12'h004, 33'h6, 33'h7);
    // teach all heads, auto start, loop monitored
    dip <= 6'b101111;
    jumper <= 1'b1;
    restart(100);
    rd(12'h004, 33'h1, 33'h7);
    chk_pin(10'h001, 10'h3f7);
    cyc(100);
    rd(12'h004, 33'h3, 33'h7);
    chk_pin(10'h3c1, 10'h3ff);
    rd(12'h008, 33'h6f, 33'h7f);
    rd(12'h00c, {1'b0, code}, 33'h1_ffff_ffff);
    jumper <= 1'b0;
    restart(100);
    rd(12'h004, 33'h2, 33'h7);
    chk_pin(10'h03d, 10'h3ff);
    guard <= 4'he;
    cyc(8);
    chk_pin(10'h009, 10'h3ff);
    guard <= 4'hf;
    cyc(8);
    chk_pin(10'h03d, 10'h3ff);
    ftest <= 1'b1;
    cyc(8);
    chk_pin(10'h00a, 10'h3ff);
    ftest <= 1'b0;
    cyc(8);
    chk_pin(10'h03d, 10'h3ff);
    code <= code ^ 32'h1;
    cyc(8);
    chk_pin(10'h009, 10'h3ff);
    code <= code ^ 32'h1;
    cyc(8);
    chk_pin(10'h03d, 10'h3ff);
    weld <= 1'b1;
    guard <= 4'he;
    cyc(120);
    rd(12'h004, 33'h8005, 33'h8007);
    chk_pin(10'h003, 10'h3f7);
    weld <= 1'b0;
    guard <= 4'hf;
    jumper <= 1'b1;
    restart(100);
    start <= 1'b0;
    cyc(8);
    rd(12'h004, 33'h2007, 33'h2007);
    chk_pin(10'h003, 10'h3f7);
    start <= 1'b1;
    dip <= 6'b010011;
    restart(200);
    rd(12'h008, 33'h53, 33'h7f);
    jumper <= 1'b0;
    start <= 1'b0;
    restart(100);
    chk_pin(10'h009, 10'h3ff);
    start <= 1'b1;
    cyc(8);
    chk_pin(10'h03d, 10'h3ff);
    ftest <= 1'b1;
    cyc(8);
    start <= 1'b0;
    cyc(8);
    ftest <= 1'b0;
    cyc(8);
    chk_pin(10'h009, 10'h3ff);
    start <= 1'b1;
    cyc(8);
    chk_pin(10'h03d, 10'h3ff);
    stop_test();
  end
endmodule // tb_top
